/* src/lgtc_regs.v */
// configuration register bank of a single channel t1/e1/j1 line
// interface: global mode, impedance select, jitter attenuator set-up
// and the first transmit configuration register, plus the small
// transmit front end that those settings steer.
// assumes an apb master on pclk; transmit clock and data arrive from
// pins and are synchronised before use.
//
// Notes on behaviour
// - bit 2 of global config: 0 selects e1, 1 selects t1/j1; reset 0.
// - interrupt pin style: x0 open-drain low, 01 push-pull low, 11 high.
// - tx impedance 000-011 internal; 1xx external, only honoured in e1.
// - rx impedance 000-011 internal 75/120/100/110; 1xx external.
// - jitter placement: 00/10 off, 01 transmit path, 11 receive path.
// - jitter depth: 00 gives 128, 01 gives 64, 1x gives 32 bits.
// - jitter bandwidth bit picks the wide or narrow corner per standard.
// - power-down bit 4 set powers transmitter off, driver high impedance.
// - data polarity bit: 0 active high, 1 active low tx inputs.
// - clock edge bit: 0 samples on falling, 1 on rising tx clock edge.
// - tx mode 00: single rail data through hdb3/b8zs encoder and shaper.
// - tx mode 01: single rail data through ami encoder and shaper.
// - tx mode 1x: encoder bypassed, dual rail data taken directly.
// - soft reset restores defaults except the line standard bit.
`include "lgtc_consts.vh"

module lgtc_regs #(
  parameter ADDR_W = 8,
  parameter SETTLE_CYCLES = `LGTC_SETTLE_CYCLES
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire int_request,
  input wire tx_line_clock,
  input wire tx_single_rail_in,
  input wire tx_positive_rail_in,
  input wire tx_negative_rail_in,
  output reg line_standard_select,
  output reg clock_settling,
  output reg int_pin_out,
  output reg int_pin_oe,
  output reg tx_term_external,
  output reg [1:0] tx_term_select,
  output reg rx_term_external,
  output reg [1:0] rx_term_select,
  output reg jitter_in_tx,
  output reg jitter_in_rx,
  output reg [7:0] jitter_depth_bits,
  output reg jitter_bandwidth,
  output reg jitter_limit_mode,
  output reg [1:0] tx_encoder_mode,
  output reg tx_pos_out,
  output reg tx_neg_out,
  output reg tx_line_oe
);

  // ===================================================================
  // functions
  // ===================================================================
  // external matching when the code's top bit is set and it is allowed
  function term_ext;
    input [2:0] code;
    input allow;
    begin
      term_ext = code[2] & allow;
    end
  endfunction

  function [5:0] addr_index;
    input [ADDR_W-1:0] a;
    begin
      addr_index = a[7:2];
    end
  endfunction

  // ===================================================================
  // registers
  // ===================================================================
  reg [7:0] global_config_q;
  reg [7:0] line_impedance_select_q;
  reg [7:0] jitter_atten_config_q;
  reg [7:0] transmit_config_zero_q;
  reg [12:0] settle_cnt_q;
  reg [7:0] rd_data_d;
  reg rd_err_d;

  wire [5:0] idx = addr_index(paddr);
  wire access = psel & penable;
  wire wr_done = access & pready & pwrite;
  wire wr_gc = wr_done & (idx == `LGTC_IDX_GLOBAL_CONFIG);
  wire wr_li = wr_done & (idx == `LGTC_IDX_LINE_IMPEDANCE);
  wire wr_jc = wr_done & (idx == `LGTC_IDX_JITTER_CONFIG);
  wire wr_tc = wr_done & (idx == `LGTC_IDX_TX_CONFIG_ZERO);
  wire soft_rst = wr_done & (idx == `LGTC_IDX_SOFT_RESET);

  wire std_t1 = global_config_q[`LGTC_GC_LINE_STD];
  wire [7:0] gc_wr = pwdata[7:0] & `LGTC_MASK_GLOBAL_CONFIG;

  // ===================================================================
  // apb slave: one wait state, answer registered
  // ===================================================================
  always @* begin
    rd_data_d = 8'h00;
    rd_err_d = 1'b0;
    case (idx)
      `LGTC_IDX_SOFT_RESET: rd_data_d = 8'h00;
      `LGTC_IDX_GLOBAL_CONFIG: rd_data_d = global_config_q;
      `LGTC_IDX_LINE_IMPEDANCE: rd_data_d = line_impedance_select_q;
      `LGTC_IDX_JITTER_CONFIG: rd_data_d = jitter_atten_config_q;
      `LGTC_IDX_TX_CONFIG_ZERO: rd_data_d = transmit_config_zero_q;
      default: rd_err_d = 1'b1;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access & ~pready;
      if (access & ~pready) begin
        prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_data_d};
        pslverr <= rd_err_d;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // ===================================================================
  // configuration registers
  // ===================================================================
  // reserved bits are masked on write so they stay zero on read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_config_q <= `LGTC_RST_GLOBAL_CONFIG;
      line_impedance_select_q <= `LGTC_RST_LINE_IMPEDANCE;
      jitter_atten_config_q <= `LGTC_RST_JITTER_CONFIG;
      transmit_config_zero_q <= `LGTC_RST_TX_CONFIG_ZERO;
    end else if (soft_rst) begin
      // the line standard survives a soft reset
      global_config_q <= (`LGTC_RST_GLOBAL_CONFIG &
        ~(8'h01 << `LGTC_GC_LINE_STD)) |
        (global_config_q & (8'h01 << `LGTC_GC_LINE_STD));
      line_impedance_select_q <= `LGTC_RST_LINE_IMPEDANCE;
      jitter_atten_config_q <= `LGTC_RST_JITTER_CONFIG;
      transmit_config_zero_q <= `LGTC_RST_TX_CONFIG_ZERO;
    end else begin
      if (wr_gc)
        global_config_q <= gc_wr;
      if (wr_li)
        line_impedance_select_q <= pwdata[7:0] &
          `LGTC_MASK_LINE_IMPEDANCE;
      if (wr_jc)
        jitter_atten_config_q <= pwdata[7:0] &
          `LGTC_MASK_JITTER_CONFIG;
      if (wr_tc)
        transmit_config_zero_q <= pwdata[7:0] &
          `LGTC_MASK_TX_CONFIG_ZERO;
    end
  end

  // ===================================================================
  // line standard settle window
  // ===================================================================
  // flag only: the bus still answers, pacing is the host's duty
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_cnt_q <= 13'h0000;
      clock_settling <= 1'b0;
    end else if (wr_gc &&
                 gc_wr[`LGTC_GC_LINE_STD] != std_t1) begin
      settle_cnt_q <= SETTLE_CYCLES[12:0];
      clock_settling <= 1'b1;
    end else if (settle_cnt_q != 13'h0000) begin
      settle_cnt_q <= settle_cnt_q - 13'h0001;
      clock_settling <= (settle_cnt_q != 13'h0001);
    end else begin
      clock_settling <= 1'b0;
    end
  end

  // ===================================================================
  // decoded configuration outputs
  // ===================================================================
  wire [1:0] int_style = global_config_q[`LGTC_GC_INT_HI:`LGTC_GC_INT_LO];
  wire [2:0] tx_term =
    line_impedance_select_q[`LGTC_LI_TX_HI:`LGTC_LI_TX_LO];
  wire [2:0] rx_term =
    line_impedance_select_q[`LGTC_LI_RX_HI:`LGTC_LI_RX_LO];
  wire [1:0] ja_place =
    jitter_atten_config_q[`LGTC_JC_PLACE_HI:`LGTC_JC_PLACE_LO];
  wire [1:0] ja_depth =
    jitter_atten_config_q[`LGTC_JC_DEPTH_HI:`LGTC_JC_DEPTH_LO];
  wire [1:0] tx_mode =
    transmit_config_zero_q[`LGTC_TC_MODE_HI:`LGTC_TC_MODE_LO];
  wire tx_power_down = transmit_config_zero_q[`LGTC_TC_POWER_DOWN];
  wire tx_invert = transmit_config_zero_q[`LGTC_TC_DATA_POL];
  wire tx_rise = transmit_config_zero_q[`LGTC_TC_CLK_EDGE];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_standard_select <= 1'b0;
      int_pin_out <= 1'b0;
      int_pin_oe <= 1'b0;
      tx_term_external <= 1'b0;
      tx_term_select <= 2'h0;
      rx_term_external <= 1'b0;
      rx_term_select <= 2'h0;
      jitter_in_tx <= 1'b0;
      jitter_in_rx <= 1'b0;
      jitter_depth_bits <= 8'h80;
      jitter_bandwidth <= 1'b0;
      jitter_limit_mode <= 1'b1;
      tx_encoder_mode <= `LGTC_ENC_ZERO_SUB;
    end else begin
      line_standard_select <= std_t1;
      // open drain pulls low only; push-pull always drives
      if (!int_style[0]) begin
        int_pin_out <= 1'b0;
        int_pin_oe <= int_request;
      end else begin
        int_pin_out <= int_style[1] ? int_request : ~int_request;
        int_pin_oe <= 1'b1;
      end
      // t1/j1 never uses external transmit resistors
      tx_term_external <= term_ext(tx_term, ~std_t1);
      tx_term_select <= tx_term[1:0];
      rx_term_external <= term_ext(rx_term, 1'b1);
      rx_term_select <= rx_term[1:0];
      jitter_in_tx <= (ja_place == 2'h1);
      jitter_in_rx <= (ja_place == 2'h3);
      case (ja_depth)
        2'h0: jitter_depth_bits <= 8'h80;
        2'h1: jitter_depth_bits <= 8'h40;
        default: jitter_depth_bits <= 8'h20;
      endcase
      // the analog loop reads the corner with the line standard
      jitter_bandwidth <= jitter_atten_config_q[`LGTC_JC_BW];
      jitter_limit_mode <= jitter_atten_config_q[`LGTC_JC_LIMIT];
      case (tx_mode)
        2'h0: tx_encoder_mode <= `LGTC_ENC_ZERO_SUB;
        2'h1: tx_encoder_mode <= `LGTC_ENC_AMI;
        default: tx_encoder_mode <= `LGTC_ENC_BYPASS;
      endcase
    end
  end

  // ===================================================================
  // transmit front end
  // ===================================================================
  // two-flop synchronisers; the first stage feeds only the second
  reg [3:0] sync1_q;
  reg [3:0] sync2_q;
  reg clk_prev_q;
  reg ami_sign_q;
  reg [3:0] zero_run_q;

  wire tx_line_clock_s = sync2_q[0];
  wire d_single = sync2_q[1] ^ tx_invert;
  wire d_pos = sync2_q[2] ^ tx_invert;
  wire d_neg = sync2_q[3] ^ tx_invert;
  wire edge_rise = tx_line_clock_s & ~clk_prev_q;
  wire edge_fall = ~tx_line_clock_s & clk_prev_q;
  wire sample = tx_rise ? edge_rise : edge_fall;
  // e1 substitutes after four zeros, t1 after eight
  wire [3:0] zero_limit = std_t1 ? 4'h8 : 4'h4;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
      clk_prev_q <= 1'b0;
    end else begin
      sync1_q <= {tx_negative_rail_in, tx_positive_rail_in,
                  tx_single_rail_in, tx_line_clock};
      sync2_q <= sync1_q;
      clk_prev_q <= tx_line_clock_s;
    end
  end

  // substitution is simplified to a violation pulse at the zero run
  // limit; the shaper downstream forms the full code pattern
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_pos_out <= 1'b0;
      tx_neg_out <= 1'b0;
      tx_line_oe <= 1'b1;
      ami_sign_q <= 1'b0;
      zero_run_q <= 4'h0;
    end else if (soft_rst || tx_power_down) begin
      tx_pos_out <= 1'b0;
      tx_neg_out <= 1'b0;
      tx_line_oe <= ~tx_power_down;
      ami_sign_q <= 1'b0;
      zero_run_q <= 4'h0;
    end else begin
      tx_line_oe <= 1'b1;
      if (sample) begin
        if (tx_mode[1]) begin
          tx_pos_out <= d_pos;
          tx_neg_out <= d_neg;
        end else if (d_single) begin
          tx_pos_out <= ~ami_sign_q;
          tx_neg_out <= ami_sign_q;
          ami_sign_q <= ~ami_sign_q;
          zero_run_q <= 4'h0;
        end else if (!tx_mode[0] &&
                     zero_run_q == zero_limit - 4'h1) begin
          // violation: same polarity as the previous mark
          tx_pos_out <= ami_sign_q;
          tx_neg_out <= ~ami_sign_q;
          zero_run_q <= 4'h0;
        end else begin
          tx_pos_out <= 1'b0;
          tx_neg_out <= 1'b0;
          if (zero_run_q != 4'hF)
            zero_run_q <= zero_run_q + 4'h1;
        end
      end
    end
  end

endmodule

/* shared/lgtc_consts.vh */
// register map, field positions, reset values and timing counts for the
// line interface configuration bank.
// assumes a 25 MHz pclk and 32-bit apb data, one register per word.
`ifndef LGTC_CONSTS_VH
`define LGTC_CONSTS_VH

// =====================================================================
// register indices (byte address is four times the index)
// =====================================================================
`define LGTC_IDX_SOFT_RESET 6'h01
`define LGTC_IDX_GLOBAL_CONFIG 6'h02
`define LGTC_IDX_LINE_IMPEDANCE 6'h03
`define LGTC_IDX_JITTER_CONFIG 6'h04
`define LGTC_IDX_TX_CONFIG_ZERO 6'h05

// =====================================================================
// reset values and writable-bit masks
// =====================================================================
`define LGTC_RST_GLOBAL_CONFIG 8'h00
`define LGTC_RST_LINE_IMPEDANCE 8'h00
`define LGTC_RST_JITTER_CONFIG 8'h20
`define LGTC_RST_TX_CONFIG_ZERO 8'h00
`define LGTC_MASK_GLOBAL_CONFIG 8'h07
`define LGTC_MASK_LINE_IMPEDANCE 8'h3F
`define LGTC_MASK_JITTER_CONFIG 8'h3F
`define LGTC_MASK_TX_CONFIG_ZERO 8'h1F

// =====================================================================
// field positions
// =====================================================================
`define LGTC_GC_LINE_STD 2
`define LGTC_GC_INT_HI 1
`define LGTC_GC_INT_LO 0
`define LGTC_LI_TX_HI 5
`define LGTC_LI_TX_LO 3
`define LGTC_LI_RX_HI 2
`define LGTC_LI_RX_LO 0
`define LGTC_JC_LIMIT 5
`define LGTC_JC_PLACE_HI 4
`define LGTC_JC_PLACE_LO 3
`define LGTC_JC_DEPTH_HI 2
`define LGTC_JC_DEPTH_LO 1
`define LGTC_JC_BW 0
`define LGTC_TC_POWER_DOWN 4
`define LGTC_TC_DATA_POL 3
`define LGTC_TC_CLK_EDGE 2
`define LGTC_TC_MODE_HI 1
`define LGTC_TC_MODE_LO 0

// =====================================================================
// encoder modes presented to the line side
// =====================================================================
`define LGTC_ENC_ZERO_SUB 2'h0
`define LGTC_ENC_AMI 2'h1
`define LGTC_ENC_BYPASS 2'h2

// =====================================================================
// timing
// =====================================================================
`define LGTC_CLK_PERIOD_NS 40
`define LGTC_SETTLE_NS 50000
`define LGTC_SETTLE_CYCLES \
  ((`LGTC_SETTLE_NS + `LGTC_CLK_PERIOD_NS - 1) / `LGTC_CLK_PERIOD_NS)

`endif

/* verif/lgtc_regs_monitor.sv */
// concurrent checks on the configuration bank's apb side and decoded outputs.
// assumes binding to lgtc_regs; paddr carries byte addresses (4 x index).
module lgtc_regs_monitor #(
  parameter ADDR_W = 8
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire int_request,
  input wire line_standard_select,
  input wire int_pin_out,
  input wire int_pin_oe,
  input wire tx_term_external,
  input wire [1:0] tx_term_select,
  input wire rx_term_external,
  input wire [1:0] rx_term_select,
  input wire jitter_in_tx,
  input wire jitter_in_rx,
  input wire [7:0] jitter_depth_bits,
  input wire jitter_bandwidth,
  input wire [1:0] tx_encoder_mode,
  input wire tx_line_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // decoded outputs are judged on reads, when the register has settled
  wire rd = pready && !pwrite;
  wire [7:0] d = prdata[7:0];
  wire [7:0] msk = paddr == 8'h08 ? 8'h07 : paddr == 8'h14 ? 8'h1F :
    (paddr == 8'h0C || paddr == 8'h10) ? 8'h3F : 8'h00;
  AST_READY_WAIT:
  assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  AST_READY_PULSE:
  assert property (pready |=> !pready) else $error("pready held");
  AST_UNMAPPED_ERR:
  assert property (pready |-> pslverr == !(paddr inside
    {8'h04, 8'h08, 8'h0C, 8'h10, 8'h14})) else $error("bad pslverr");
  AST_RESERVED_ZERO:
  assert property (rd |-> prdata[31:8] == 24'h0 && (d & ~msk) == 8'h00)
    else $error("reserved bits read nonzero");
  AST_LINE_STD:
  assert property (rd && paddr == 8'h08 |-> line_standard_select == d[2])
    else $error("line standard output wrong");
  AST_INT_STYLE:
  assert property (rd && paddr == 8'h08 && $stable(int_request) |->
    int_pin_oe == (d[0] | int_request) && (!int_pin_oe ||
    int_pin_out == (d[0] & (d[1] ~^ int_request))))
    else $error("interrupt pin style wrong");
  AST_TX_TERM:
  assert property (rd && paddr == 8'h0C |-> tx_term_external ==
    (d[5] && !line_standard_select) && (d[5] || tx_term_select == d[4:3]))
    else $error("tx impedance wrong");
  AST_RX_TERM:
  assert property (rd && paddr == 8'h0C |-> rx_term_external == d[2] &&
    (d[2] || rx_term_select == d[1:0])) else $error("rx impedance wrong");
  AST_JITTER_PLACE:
  assert property (rd && paddr == 8'h10 |-> jitter_in_tx ==
    (d[4:3] == 2'b01) && jitter_in_rx == (d[4:3] == 2'b11))
    else $error("jitter placement wrong");
  AST_JITTER_DEPTH:
  assert property (rd && paddr == 8'h10 |-> jitter_depth_bits ==
    (d[2] ? 8'h20 : d[1] ? 8'h40 : 8'h80)) else $error("depth wrong");
  AST_JITTER_BW:
  assert property (rd && paddr == 8'h10 |-> jitter_bandwidth == d[0])
    else $error("bandwidth wrong");
  AST_TX_OE:
  assert property (rd && paddr == 8'h14 |-> tx_line_oe == !d[4])
    else $error("driver enable wrong");
  AST_TX_MODE:
  assert property (rd && paddr == 8'h14 |-> tx_encoder_mode ==
    (d[1] ? 2'h2 : {1'b0, d[0]})) else $error("encoder mode wrong");
endmodule

bind lgtc_regs lgtc_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.pclk, .presetn,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .int_request,
  .line_standard_select, .int_pin_out, .int_pin_oe, .tx_term_external,
  .tx_term_select, .rx_term_external, .rx_term_select, .jitter_in_tx,
  .jitter_in_rx, .jitter_depth_bits, .jitter_bandwidth, .tx_encoder_mode,
  .tx_line_oe);

/* verif/tb_top.sv */
// self-checking bench for the configuration bank, apb master inside.
// assumes lgtc_regs with a shortened settle count; 40 ns pclk.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic int_request = 0, tx_line_clock = 0, tx_single_rail_in = 0;
  logic tx_positive_rail_in = 0, tx_negative_rail_in = 0, err;
  logic pready, pslverr, line_standard_select, clock_settling;
  logic int_pin_out, int_pin_oe, tx_term_external, rx_term_external;
  logic [1:0] tx_term_select, rx_term_select, tx_encoder_mode;
  logic jitter_in_tx, jitter_in_rx, jitter_bandwidth, jitter_limit_mode;
  logic [7:0] jitter_depth_bits;
  logic tx_pos_out, tx_neg_out, tx_line_oe;
  int bad_count = 0, samples_checked = 0;
  // 50 us would be 1250 cycles; a short window keeps the run brief
  localparam int SETTLE = 10;
  lgtc_regs #(.SETTLE_CYCLES(SETTLE)) u_lgtc_regs (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .int_request, .tx_line_clock, .tx_single_rail_in, .tx_positive_rail_in,
    .tx_negative_rail_in, .line_standard_select, .clock_settling,
    .int_pin_out, .int_pin_oe, .tx_term_external, .tx_term_select,
    .rx_term_external, .rx_term_select, .jitter_in_tx, .jitter_in_rx,
    .jitter_depth_bits, .jitter_bandwidth, .jitter_limit_mode,
    .tx_encoder_mode, .tx_pos_out, .tx_neg_out, .tx_line_oe);
  initial forever #20 pclk = ~pclk;
  // ====================
  // bus and compare helpers
  task automatic chk(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, v};
    @(posedge pclk);
    penable <= 1;
    // no cycle limit here: only the watchdog may end a stuck transfer
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic wr(input logic [7:0] a, v);
    apb(1, a, v);
  endtask
  task automatic rchk(input string s, input logic [7:0] a, e);
    apb(0, a, 8'h00);
    chk(s, {24'h0, e}, rd);
  endtask
  // host keeps off the bus while internal clocking settles
  task automatic settle;
    @(posedge pclk);
    chk("settling", 1, clock_settling);
    repeat (SETTLE - 1) @(posedge pclk);
    chk("settling", 1, clock_settling);
    @(posedge pclk);
    chk("settling", 0, clock_settling);
  endtask
  task automatic txe(input logic c, p, n);
    @(posedge pclk);
    tx_line_clock <= c;
    tx_single_rail_in <= p;
    tx_positive_rail_in <= p;
    tx_negative_rail_in <= n;
    repeat (8) @(posedge pclk);
  endtask
  // one single rail bit: data set on the rise, taken on the fall
  task automatic tbit(input logic s, input logic [1:0] e);
    txe(1, s, 0);
    txe(0, s, 0);
    chk("rails", e, {tx_pos_out, tx_neg_out});
  endtask
  // ====================
  // scenarios
  task automatic t_defaults;
    rchk("global", 8'h08, 8'h00);
    rchk("imped", 8'h0C, 8'h00);
    rchk("jitter", 8'h10, 8'h20);
    rchk("txcfg", 8'h14, 8'h00);
    rchk("unmapped", 8'h18, 8'h00);
    chk("slverr", 1, err);
    $display("test defaults done");
  endtask
  task automatic t_masks;
    wr(8'h08, 8'hFC);
    settle;
    rchk("global", 8'h08, 8'h04);
    wr(8'h0C, 8'hFF);
    rchk("imped", 8'h0C, 8'h3F);
    wr(8'h08, 8'h00);
    settle;
    rchk("imped", 8'h0C, 8'h3F);
    wr(8'h14, 8'hFF);
    rchk("txcfg", 8'h14, 8'h1F);
    wr(8'h00, 8'hFF);
    chk("slverr", 1, err);
    $display("test masks done");
  endtask
  task automatic t_codes;
    for (int i = 0; i < 8; i++) begin
      wr(8'h0C, {2'h0, i[2:0], i[2:0]});
      rchk("imped", 8'h0C, {2'h0, i[2:0], i[2:0]});
      wr(8'h10, {3'h0, i[1:0], i[1:0], i[2]});
      rchk("jitter", 8'h10, {3'h0, i[1:0], i[1:0], i[2]});
      chk("depth", i[1] ? 8'h20 : i[0] ? 8'h40 : 8'h80,
        jitter_depth_bits);
      wr(8'h14, {6'h0, i[1:0]});
      rchk("txcfg", 8'h14, {6'h0, i[1:0]});
      chk("mode", i[1] ? 2 : i[0], tx_encoder_mode);
    end
    $display("test codes done");
  endtask
  task automatic t_int;
    for (int i = 0; i < 8; i++) begin
      @(posedge pclk);
      int_request <= i[0];
      wr(8'h08, {6'h0, i[2:1]});
      rchk("global", 8'h08, {6'h0, i[2:1]});
      chk("int_oe", i[1] | i[0], int_pin_oe);
      chk("int_out", i[1] & (i[2] ~^ i[0]), int_pin_out);
    end
    $display("test interrupt style done");
  endtask
  task automatic t_soft;
    wr(8'h08, 8'h07);
    settle;
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h0B);
    wr(8'h04, 8'h00);
    rchk("global", 8'h08, 8'h04);
    rchk("jitter", 8'h10, 8'h20);
    rchk("txcfg", 8'h14, 8'h00);
    rchk("imped", 8'h0C, 8'h00);
    chk("limit", 1, jitter_limit_mode);
    wr(8'h08, 8'h00);
    settle;
    $display("test soft reset done");
  endtask
  task automatic t_tx;
    wr(8'h14, 8'h02);
    txe(1, 1, 0);
    txe(0, 1, 0);
    chk("rails", 2'b10, {tx_pos_out, tx_neg_out});
    txe(1, 0, 1);
    chk("rails", 2'b10, {tx_pos_out, tx_neg_out});
    txe(0, 0, 1);
    chk("rails", 2'b01, {tx_pos_out, tx_neg_out});
    wr(8'h14, 8'h0E);
    txe(1, 0, 1);
    chk("rails", 2'b10, {tx_pos_out, tx_neg_out});
    wr(8'h14, 8'h1E);
    txe(0, 1, 0);
    chk("oe", 0, tx_line_oe);
    chk("rails", 2'b00, {tx_pos_out, tx_neg_out});
    wr(8'h14, 8'h00);
    repeat (3) @(posedge pclk);
    chk("oe", 1, tx_line_oe);
    // marks alternate in ami; zero substitution violates after four zeros
    wr(8'h14, 8'h01);
    tbit(1, 2'b10);
    tbit(1, 2'b01);
    wr(8'h14, 8'h00);
    tbit(0, 2'b00);
    tbit(0, 2'b00);
    tbit(0, 2'b00);
    tbit(0, 2'b01);
    $display("test transmit done");
  endtask
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1;
    t_defaults();
    t_masks();
    t_codes();
    t_int();
    t_soft();
    t_tx();
    final_report();
  end
  // whole run is under a thousand cycles; this limit only catches a hang
  initial begin
    #400us;
    bad_count++;
    final_report();
  end
endmodule
